// ---- design/sfpe_pkg.sv ----
// Functional notes
// - Wrap command is 77H, 24 dummy bits, one wrap byte, then chip select rises.
// - Wrap-disable 0 enables wrapping; length code picks 8/16/32/64 bytes in a page.
// - Wrap-disable comes up set; host rewrites it as 1 to leave wrapping.
// - Stored wrap fields apply to all later quad reads until changed.
// - Program and erase run only with the write latch set beforehand.
// - Page write is 02H, three address bytes, data bytes on the serial input.
// - Data past the page end wraps to the page start.
// - Over 256 bytes, only the final 256 bytes are programmed.
// - Under 256 bytes, untouched bytes of the page stay unchanged.
// - Program runs only if chip select rises on a whole data byte.
// - Erase runs only if chip select rises right after the address.
// - Valid command end starts a timed cycle; busy is 1 throughout, then 0.
// - Status stays readable during a cycle; write latch clears before it ends.
// - Page writes into a protected page are not executed.
// - Quad page write is 32H with data on four lines; needs quad enable.
// - Sector clear 20H erases the sector holding the address.
// - Block clear 52H (32KB) or D8H (64KB) erases the holding block.
// - Erases of a protected area are not executed.
package sfpe_pkg;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_WRAP_SET = 8'h77;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
    localparam logic [7:0] OP_SECTOR_CLEAR = 8'h20;
    localparam logic [7:0] OP_BLOCK32_CLEAR = 8'h52;
    localparam logic [7:0] OP_BLOCK64_CLEAR = 8'hD8;
    localparam logic [5:0] HDR_OP = 6'h08;
    localparam logic [5:0] HDR_LAST_OP_BIT = 6'h07;
    localparam logic [5:0] HDR_LAST_ADDR_BIT = 6'h1F;
    localparam logic [5:0] HDR_FULL = 6'h20;
    localparam logic [2:0] STEP_SERIAL = 3'h1;
    localparam logic [2:0] STEP_QUAD = 3'h4;
    localparam int PAGE_BYTES = 256;
    localparam int SECTOR_BYTES = 4096;
    localparam int BLOCK32_BYTES = 32768;
    localparam int BLOCK64_BYTES = 65536;
    localparam int MEM_ADDR_W = 18;
    localparam logic WRAP_DIS_RESET = 1'b1;
    localparam logic [1:0] WRAP_LEN_RESET = 2'h0;
    localparam int WRAP_DIS_POS = 4;
    localparam int WRAP_LEN_LSB = 5;
    localparam logic [6:0] WRAP_BASE_BYTES = 7'h08;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int IO_SO_POS = 1;
    localparam int REF_CLK_MHZ = 100;
    localparam int PAGE_WRITE_CYCLE_TIME_US = 500;
    localparam int SECTOR_CLEAR_CYCLE_TIME_US = 50000;
    localparam int BLOCK_CLEAR_CYCLE_TIME_US = 150000;
    localparam int PAGE_WRITE_CYCLES = PAGE_WRITE_CYCLE_TIME_US * REF_CLK_MHZ;
    localparam int SECTOR_CLEAR_CYCLES = SECTOR_CLEAR_CYCLE_TIME_US * REF_CLK_MHZ;
    localparam int BLOCK_CLEAR_CYCLES = BLOCK_CLEAR_CYCLE_TIME_US * REF_CLK_MHZ;

    typedef struct packed {
        logic [7:0] op;
        logic [23:0] addr;
        logic [5:0] hdr;
        logic [2:0] ph;
        logic [1:0] nbytes;
        logic [7:0] first_byte;
    } sfpe_frame_s;

    typedef enum {ST_IDLE, ST_WALK, ST_WAIT} sfpe_state_e;
endpackage

// ---- design/sfpe_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfpe_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_q <= '0;
            q_out <= '0;
        end
        else
        begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- design/sfpe_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfpe_top #(
    parameter int ADDR_W = sfpe_pkg::MEM_ADDR_W,
    parameter int PAGE_WRITE_CYCLES = sfpe_pkg::PAGE_WRITE_CYCLES,
    parameter int SECTOR_CLEAR_CYCLES = sfpe_pkg::SECTOR_CLEAR_CYCLES,
    parameter int BLOCK_CLEAR_CYCLES = sfpe_pkg::BLOCK_CLEAR_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic [3:0] spi_io_in,
    output logic [3:0] spi_io_out,
    output logic [3:0] spi_io_oe_out,
    input wire logic quad_lane_enable_bit_in,
    input wire logic [4:0] protect_level_bits_in,
    input wire logic [ADDR_W-1:0] mem_rd_addr_in,
    output logic [7:0] mem_rd_data_out,
    output logic cycle_busy_bit_out,
    output logic write_latch_bit_out,
    output logic wrap_disable_bit_out,
    output logic [1:0] wrap_length_bits_out,
    output logic [6:0] wrap_section_bytes_out
);
    import sfpe_pkg::*;

    localparam logic [31:0] MEM_BYTES = 32'(1) << ADDR_W;

    // Link domain: frame capture on the serial clock
    sfpe_frame_s fr_q;
    sfpe_frame_s fr_d;
    sfpe_frame_s cur;
    logic started_q;
    logic [7:0] sh_q;
    logic [2:0] rc_q;
    logic [7:0] idx_q;
    logic [PAGE_BYTES-1:0] mask_q;
    logic [7:0] buf_q [PAGE_BYTES];
    logic [1:0] stat_l;
    logic [3:0] io_out_q;
    logic [3:0] io_oe_q;

    // Core-domain status shown to the link through a synchroniser
    logic busy_q;
    logic wel_q;

    sfpe_sync #(.WIDTH(2)) u_stat_sync (
        .clk_in(spi_clk_in),
        .nrst_in(nrst_in),
        .d_in({wel_q, busy_q}),
        .q_out(stat_l)
    );

    wire busy_l = stat_l[0];
    wire quad_data = (cur.op == OP_QUAD_PAGE_WRITE) && (cur.hdr == HDR_FULL);
    wire [2:0] step = quad_data ? STEP_QUAD : STEP_SERIAL;
    wire [7:0] sh_next = quad_data ? {sh_q[3:0], spi_io_in} : {sh_q[6:0], spi_io_in[0]};
    wire [2:0] ph_sum = cur.ph + step;
    wire byte_done = (cur.hdr == HDR_FULL) && (ph_sum == 3'h0);
    wire link_prog = (cur.op == OP_PAGE_WRITE) || (cur.op == OP_QUAD_PAGE_WRITE);
    wire buf_open = link_prog && !busy_l;
    wire [7:0] stat_byte = {6'h00, stat_l[1], stat_l[0]};
    wire rd_active = started_q && (fr_q.op == OP_STATUS_READ) && (fr_q.hdr >= HDR_OP);

    assign cur = started_q ? fr_q : '0;

    always_comb
    begin
        fr_d = cur;
        if (cur.hdr != HDR_FULL)
        begin
            fr_d.hdr = cur.hdr + 6'h01;
            if (cur.hdr == HDR_LAST_OP_BIT)
                fr_d.op = sh_next;
            else if (cur.hdr > HDR_LAST_OP_BIT)
                fr_d.addr = {cur.addr[22:0], spi_io_in[0]};
        end
        else
        begin
            fr_d.ph = ph_sum;
            if (byte_done && (cur.nbytes != 2'h3))
                fr_d.nbytes = cur.nbytes + 2'h1;
            if (byte_done && (cur.nbytes == 2'h0))
                fr_d.first_byte = sh_next;
        end
    end

    always_ff @(posedge spi_clk_in or posedge spi_cs_n_in or negedge nrst_in)
    begin
        if (!nrst_in)
            started_q <= 1'b0;
        else if (spi_cs_n_in)
            started_q <= 1'b0;
        else
            started_q <= 1'b1;
    end

    always_ff @(posedge spi_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            fr_q <= '0;
            sh_q <= '0;
            rc_q <= '0;
        end
        else
        begin
            fr_q <= fr_d;
            sh_q <= sh_next;
            rc_q <= started_q ? rc_q + 3'h1 : 3'h1;
        end
    end

    // Page buffer: a fresh mask per page write frame taken while not busy, bytes land at the wrapping page index
    always_ff @(posedge spi_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            idx_q <= '0;
            mask_q <= '0;
        end
        else if (buf_open && (cur.hdr == HDR_LAST_ADDR_BIT))
        begin
            idx_q <= {cur.addr[6:0], spi_io_in[0]};
            mask_q <= '0;
        end
        else if (buf_open && byte_done)
        begin
            idx_q <= idx_q + 8'h01;
            mask_q[idx_q] <= 1'b1;
        end
    end

    always_ff @(posedge spi_clk_in)
    begin
        if (buf_open && byte_done)
            buf_q[idx_q] <= sh_next;
    end

    // Status byte goes out MSB first on the falling edge
    always_ff @(negedge spi_clk_in or posedge spi_cs_n_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            io_out_q <= '0;
            io_oe_q <= '0;
        end
        else if (spi_cs_n_in)
        begin
            io_out_q <= '0;
            io_oe_q <= '0;
        end
        else
        begin
            io_out_q[IO_SO_POS] <= rd_active & stat_byte[~rc_q];
            io_oe_q[IO_SO_POS] <= rd_active;
        end
    end

    assign spi_io_out = io_out_q;
    assign spi_io_oe_out = io_oe_q;

    // Core domain: frame end detection and self-timed cycle
    // Synchronise the selected level so its reset value matches an idle pin
    wire cs_sel = !spi_cs_n_in;
    logic cs_sel_s;
    logic cs_prev_q;

    sfpe_sync #(.WIDTH(1)) u_cs_sync (
        .clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .d_in(cs_sel),
        .q_out(cs_sel_s)
    );

    function automatic logic prot_hit(input logic [4:0] lvl, input logic [31:0] last);
        logic [63:0] span;
        logic [63:0] bound;
        span = 64'(SECTOR_BYTES) << (lvl - 5'h01);
        bound = (span >= 64'(MEM_BYTES)) ? 64'h0 : 64'(MEM_BYTES) - span;
        return (lvl != 5'h00) && (64'(last) >= bound);
    endfunction

    wire cs_rise = cs_prev_q && !cs_sel_s;
    wire is_pp = fr_q.op == OP_PAGE_WRITE;
    wire is_qpp = fr_q.op == OP_QUAD_PAGE_WRITE;
    wire is_se = fr_q.op == OP_SECTOR_CLEAR;
    wire is_b32 = fr_q.op == OP_BLOCK32_CLEAR;
    wire is_b64 = fr_q.op == OP_BLOCK64_CLEAR;
    wire is_erase = is_se || is_b32 || is_b64;
    wire hdr_only = (fr_q.hdr == HDR_FULL) && (fr_q.nbytes == 2'h0) && (fr_q.ph == 3'h0);
    wire with_data = (fr_q.hdr == HDR_FULL) && (fr_q.nbytes != 2'h0) && (fr_q.ph == 3'h0);
    wire write_enable_command_ok = (fr_q.op == OP_WRITE_ENABLE) && (fr_q.hdr == HDR_OP);
    wire wrap_ok = (fr_q.op == OP_WRAP_SET) && (fr_q.hdr == HDR_FULL)
        && (fr_q.nbytes == 2'h1) && (fr_q.ph == 3'h0);
    wire [31:0] area_size = is_se ? 32'(SECTOR_BYTES) :
        is_b32 ? 32'(BLOCK32_BYTES) : is_b64 ? 32'(BLOCK64_BYTES) : 32'(PAGE_BYTES);
    wire [31:0] addr32 = {8'h00, fr_q.addr} & (MEM_BYTES - 32'h1);
    wire [31:0] area_base = addr32 & ~(area_size - 32'h1);
    wire [31:0] area_last = area_base + area_size - 32'h1;
    wire prot = prot_hit(protect_level_bits_in, area_last);
    wire quad_ok = is_pp || (is_qpp && quad_lane_enable_bit_in);
    wire prog_ok = quad_ok && with_data && wel_q && !prot;
    wire erase_ok = is_erase && hdr_only && wel_q && !prot;
    wire idle_rise = cs_rise && !busy_q;
    wire start = idle_rise && (prog_ok || erase_ok);
    wire [31:0] load_cycles = is_se ? 32'(SECTOR_CLEAR_CYCLES) :
        (is_b32 || is_b64) ? 32'(BLOCK_CLEAR_CYCLES) : 32'(PAGE_WRITE_CYCLES);

    sfpe_state_e state_q;
    sfpe_state_e state_d;
    logic erase_q;
    logic [31:0] base_q;
    logic [31:0] len_q;
    logic [31:0] walk_q;
    logic [31:0] timer_q;
    logic wrap_dis_q;
    logic [1:0] wrap_len_q;
    logic [6:0] sect_q;
    logic [7:0] rd_q;
    logic [7:0] mem_q [MEM_BYTES];

    wire [ADDR_W-1:0] walk_addr = ADDR_W'(base_q + walk_q);
    wire [7:0] walk_idx = walk_q[7:0];
    wire walk_last = walk_q == (len_q - 32'h1);
    wire timer_done = timer_q == 32'h0;
    wire [6:0] sect_d = wrap_dis_q ? 7'h00 : (WRAP_BASE_BYTES << wrap_len_q);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (start)
                    state_d = ST_WALK;
            ST_WALK:
                if (walk_last)
                    state_d = ST_WAIT;
            ST_WAIT:
                if (timer_done)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cs_prev_q <= 1'b0;
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            erase_q <= 1'b0;
            base_q <= '0;
            len_q <= '0;
            walk_q <= '0;
            timer_q <= '0;
        end
        else
        begin
            cs_prev_q <= cs_sel_s;
            state_q <= state_d;
            busy_q <= state_d != ST_IDLE;
            if (start)
            begin
                erase_q <= is_erase;
                base_q <= area_base;
                len_q <= area_size;
                walk_q <= '0;
                timer_q <= load_cycles - 32'h1;
            end
            else
            begin
                if (state_q == ST_WALK)
                    walk_q <= walk_q + 32'h1;
                if (!timer_done)
                    timer_q <= timer_q - 32'h1;
            end
        end
    end

    // Write latch and wrap settings
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wel_q <= 1'b0;
            wrap_dis_q <= WRAP_DIS_RESET;
            wrap_len_q <= WRAP_LEN_RESET;
            sect_q <= '0;
        end
        else
        begin
            if (start)
                wel_q <= 1'b0;
            else if (idle_rise && write_enable_command_ok)
                wel_q <= 1'b1;
            if (idle_rise && wrap_ok)
            begin
                wrap_dis_q <= fr_q.first_byte[WRAP_DIS_POS];
                wrap_len_q <= fr_q.first_byte[WRAP_LEN_LSB +: 2];
            end
            sect_q <= sect_d;
        end
    end

    // Array walk: erase fills ones, program ANDs in the masked bytes
    always_ff @(posedge ref_clk_in)
    begin
        if ((state_q == ST_WALK) && erase_q)
            mem_q[walk_addr] <= ERASED_BYTE;
        else if ((state_q == ST_WALK) && mask_q[walk_idx])
            mem_q[walk_addr] <= mem_q[walk_addr] & buf_q[walk_idx];
        rd_q <= mem_q[mem_rd_addr_in];
    end

    assign mem_rd_data_out = rd_q;
    assign cycle_busy_bit_out = busy_q;
    assign write_latch_bit_out = wel_q;
    assign wrap_disable_bit_out = wrap_dis_q;
    assign wrap_length_bits_out = wrap_len_q;
    assign wrap_section_bytes_out = sect_q;

    AST_WRAP_LATCH: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (idle_rise && wrap_ok) |=> (wrap_dis_q == $past(fr_q.first_byte[WRAP_DIS_POS])))
        else $error("wrap disable not taken from wrap byte");
    AST_WRAP_SECTION: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        ##1 (sect_q == (($past(wrap_dis_q)) ? 7'h00 : (7'h08 << $past(wrap_len_q)))))
        else $error("wrap section size mismatch");
    AST_NEED_LATCH: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        $rose(busy_q) |-> $past(wel_q, 2))
        else $error("cycle started without write latch");
    AST_BUSY_HOLD: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (busy_q && !timer_done) |=> busy_q)
        else $error("busy dropped before cycle time");
    AST_BUSY_START: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        start |=> busy_q ##1 busy_q)
        else $error("busy not raised on valid command end");
    AST_LATCH_CLEARED: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        $fell(busy_q) |-> !wel_q)
        else $error("write latch still set at cycle end");
    AST_PROTECT: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cs_rise && prot) |=> !$rose(busy_q))
        else $error("protected area cycle started");
    AST_QUAD_GATE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cs_rise && is_qpp && !quad_lane_enable_bit_in) |=> !$rose(busy_q))
        else $error("quad page write ran without quad enable");
    AST_BUSY_IGNORE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cs_rise && busy_q) |=> ($stable(wrap_dis_q) && $stable(wrap_len_q) && $stable(len_q)))
        else $error("command taken during cycle");
    AST_ERASE_ONES: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        ((state_q == ST_WALK) && erase_q) |=> (mem_q[$past(walk_addr)] == 8'hFF))
        else $error("erased byte not all ones");
endmodule
`default_nettype wire

// ---- verification/sfpe_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfpe_host
    import sfpe_pkg::*;
(
    output logic spi_clk_out,
    output logic spi_cs_n_out,
    output logic [3:0] spi_io_out,
    input wire logic [3:0] dev_io_in,
    input wire logic [3:0] dev_oe_in
);
    logic [3:0] drv;
    logic [7:0] dat [0:299];
    // Wire level: the device wins on lines it drives
    assign spi_io_out = (dev_oe_in & dev_io_in) | (~dev_oe_in & drv);
    initial
    begin
        spi_clk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        drv = 4'h0;
    end
    task automatic tick(input logic [3:0] v, output logic s);
        drv = v;
        #80 spi_clk_out = 1'b1;
        s = spi_io_out[1];
        #80 spi_clk_out = 1'b0;
    endtask
    // Serial clock stands still and released lines flip after each frame
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nab,
        input int nd, input int xb, input bit q);
        logic s;
        spi_cs_n_out = 1'b0;
        #80;
        for (int i = 7; i >= 0; i--)
            tick({3'h0, op[i]}, s);
        for (int i = 23; i >= 24 - nab; i--)
            tick({3'h0, a[i]}, s);
        for (int k = 0; k < nd; k++)
        begin
            if (q)
            begin
                tick(dat[k][7:4], s);
                tick(dat[k][3:0], s);
            end
            else
            begin
                for (int i = 7; i >= 0; i--)
                    tick({3'h0, dat[k][i]}, s);
            end
        end
        for (int i = 0; i < xb; i++)
            tick(4'h1, s);
        #80 spi_cs_n_out = 1'b1;
        drv = ~drv;
        #400;
    endtask
    task automatic status(output logic [7:0] st);
        logic s;
        spi_cs_n_out = 1'b0;
        #80;
        for (int i = 7; i >= 0; i--)
            tick({3'h0, OP_STATUS_READ[i]}, s);
        for (int i = 7; i >= 0; i--)
        begin
            tick(~drv, s);
            st[i] = s;
        end
        #80 spi_cs_n_out = 1'b1;
        drv = ~drv;
        #400;
    endtask
endmodule
`default_nettype wire

// ---- verification/test_sfpe_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sfpe_top;
    import sfpe_pkg::*;
    logic ref_clk;
    logic nrst;
    logic qe;
    logic [4:0] prot;
    logic [MEM_ADDR_W-1:0] rd_addr;
    logic [7:0] st;
    wire sclk;
    wire cs_n;
    wire [3:0] io;
    wire [3:0] dev_io;
    wire [3:0] dev_oe;
    wire [7:0] rd_data;
    wire busy;
    wire latch;
    wire wdis;
    wire [1:0] wlen;
    wire [6:0] wsec;
    int errors;
    int samples_checked;
    sfpe_top #(.PAGE_WRITE_CYCLES(300), .SECTOR_CLEAR_CYCLES(100),
        .BLOCK_CLEAR_CYCLES(100)) u_sfpe_top (
        .ref_clk_in(ref_clk), .nrst_in(nrst), .spi_clk_in(sclk),
        .spi_cs_n_in(cs_n), .spi_io_in(io), .spi_io_out(dev_io),
        .spi_io_oe_out(dev_oe), .quad_lane_enable_bit_in(qe),
        .protect_level_bits_in(prot), .mem_rd_addr_in(rd_addr),
        .mem_rd_data_out(rd_data), .cycle_busy_bit_out(busy),
        .write_latch_bit_out(latch), .wrap_disable_bit_out(wdis),
        .wrap_length_bits_out(wlen), .wrap_section_bytes_out(wsec));
    sfpe_host u_sfpe_host (.spi_clk_out(sclk), .spi_cs_n_out(cs_n),
        .spi_io_out(io), .dev_io_in(dev_io), .dev_oe_in(dev_oe));
    always #5 ref_clk = ~ref_clk;
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    task automatic flags(input logic b, input logic l);
        @(negedge ref_clk);
        check("busy", {7'h0, busy}, {7'h0, b});
        check("latch", {7'h0, latch}, {7'h0, l});
    endtask
    task automatic wrapchk(input logic d, input logic [1:0] l, input logic [7:0] s);
        @(negedge ref_clk);
        check("wrap disable", {7'h0, wdis}, {7'h0, d});
        check("wrap length", {6'h0, wlen}, {6'h0, l});
        check("wrap section", {1'b0, wsec}, s);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nd,
        input int xb, input bit q);
        u_sfpe_host.frame(op, a, 24, nd, xb, q);
    endtask
    task automatic write_enable_command();
        u_sfpe_host.frame(OP_WRITE_ENABLE, 24'h0, 0, 0, 0, 1'b0);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0)
        begin
            @(posedge ref_clk);
            n++;
            if (n > 40000)
            begin
                check("busy wait", 8'h01, 8'h00);
                stop_test();
            end
        end
    endtask
    task automatic mem(input logic [23:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        rd_addr <= a[MEM_ADDR_W-1:0];
        @(posedge ref_clk);
        #1;
        check("array byte", rd_data, exp);
    endtask
    initial
    begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        qe = 1'b0;
        prot = 5'h00;
        rd_addr = '0;
        errors = 0;
        samples_checked = 0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wrapchk(1'b1, 2'h0, 8'h00);
        flags(1'b0, 1'b0);
        done("reset");
        for (int c = 0; c < 4; c++)
        begin
            u_sfpe_host.dat[0] = {1'b0, c[1:0], 5'h00};
            cmd(OP_WRAP_SET, 24'h0, 1, 0, 1'b0);
            wrapchk(1'b0, c[1:0], 8'h08 << c);
        end
        u_sfpe_host.dat[0] = 8'h50;
        cmd(OP_WRAP_SET, 24'h0, 1, 1, 1'b0);
        wrapchk(1'b0, 2'h3, 8'h40);
        cmd(OP_WRAP_SET, 24'h0, 1, 0, 1'b0);
        wrapchk(1'b1, 2'h2, 8'h00);
        done("wrap");
        cmd(OP_PAGE_WRITE, 24'h001100, 1, 0, 1'b0);
        flags(1'b0, 1'b0);
        write_enable_command();
        flags(1'b0, 1'b1);
        u_sfpe_host.status(st);
        check("status", st, 8'h02);
        cmd(OP_SECTOR_CLEAR, 24'h001234, 0, 0, 1'b0);
        flags(1'b1, 1'b0);
        u_sfpe_host.status(st);
        check("status", st, 8'h01);
        write_enable_command();
        u_sfpe_host.dat[0] = 8'h00;
        cmd(OP_WRAP_SET, 24'h0, 1, 0, 1'b0);
        wait_idle();
        flags(1'b0, 1'b0);
        wrapchk(1'b1, 2'h2, 8'h00);
        mem(24'h001000, ERASED_BYTE);
        mem(24'h001FFF, ERASED_BYTE);
        done("sector");
        write_enable_command();
        cmd(OP_SECTOR_CLEAR, 24'h002000, 0, 8, 1'b0);
        flags(1'b0, 1'b1);
        cmd(OP_PAGE_WRITE, 24'h001100, 1, 3, 1'b0);
        flags(1'b0, 1'b1);
        cmd(OP_PAGE_WRITE, 24'h001100, 0, 0, 1'b0);
        flags(1'b0, 1'b1);
        u_sfpe_host.dat[0] = 8'hA5;
        u_sfpe_host.dat[1] = 8'h5A;
        u_sfpe_host.dat[2] = 8'h3C;
        u_sfpe_host.dat[3] = 8'hC3;
        cmd(OP_PAGE_WRITE, 24'h0011FE, 4, 0, 1'b0);
        flags(1'b1, 1'b0);
        wait_idle();
        mem(24'h0011FE, 8'hA5);
        mem(24'h0011FF, 8'h5A);
        mem(24'h001100, 8'h3C);
        mem(24'h001101, 8'hC3);
        mem(24'h001102, ERASED_BYTE);
        done("page");
        write_enable_command();
        cmd(OP_QUAD_PAGE_WRITE, 24'h001280, 2, 0, 1'b1);
        flags(1'b0, 1'b1);
        @(posedge ref_clk);
        qe <= 1'b1;
        for (int k = 0; k < 258; k++)
            u_sfpe_host.dat[k] = (k < 2) ? 8'h00 : (k[7:0] | 8'h80);
        cmd(OP_QUAD_PAGE_WRITE, 24'h001280, 258, 0, 1'b1);
        flags(1'b1, 1'b0);
        wait_idle();
        mem(24'h001280, 8'h80);
        mem(24'h001281, 8'h81);
        mem(24'h001282, 8'h82);
        mem(24'h001200, 8'h80);
        done("quad");
        @(posedge ref_clk);
        prot <= 5'h01;
        write_enable_command();
        cmd(OP_PAGE_WRITE, 24'h03F000, 1, 0, 1'b0);
        flags(1'b0, 1'b1);
        cmd(OP_BLOCK64_CLEAR, 24'h030000, 0, 0, 1'b0);
        flags(1'b0, 1'b1);
        @(posedge ref_clk);
        prot <= 5'h00;
        cmd(OP_BLOCK32_CLEAR, 24'h001234, 0, 0, 1'b0);
        flags(1'b1, 1'b0);
        wait_idle();
        mem(24'h001280, ERASED_BYTE);
        mem(24'h0011FE, ERASED_BYTE);
        done("block");
        stop_test();
    end
endmodule
`default_nettype wire
